// [verilog/pipe_tx_channel.sv]
// ==========================================================
// Summary of operation
// R1: Controller asserts clock-gen reset, awaits acknowledge.
// R2: Controller asserts both holds when calibration idle.
// R3: Controller waits for both reset acknowledges high.
// R4: Analog acknowledge rises once PMA held.
// R5: Controller drops analog hold after PCS acknowledge.
// R6: Analog acknowledge falls once PMA released.
// R7: Controller waits analog acknowledge low.
// R8: Controller drops clock-gen reset, awaits acknowledge drop.
// R9: PCS hold released minimum interval after lock.
// R10: Sequence ends when PCS acknowledge low.
// R11: Vendor controller digital resets set manual.
// R12: Avoid resetting PLL and channels in PIPE.
// R13: OR calibration busy unless dedicated input.
// R14: Bonding master index 0,1,2,4,8 by width.
// R15: Auto master is middle lane, slot 1/4.
// R16: Power up Gen1; Gen3 runs 8 Gbps.
// R17: Single-lane Gen3 has two PLL inputs; select 0.
// R18: Analog hold gated by clock-gen acknowledge.
// R19: Lock seen is lock and not clock-gen acknowledge.
// R20: Controller steps singly, busy until done.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module pipe_tx_channel
  import pipe_tx_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic clock_gen_block_reset,
  input wire logic tx_analog_hold,
  input wire logic tx_pcs_hold,
  output logic clock_gen_block_reset_ack,
  output logic tx_analog_reset_ack,
  output logic tx_pcs_reset_ack,
  output logic pll_locked,
  output logic pll_cal_busy,
  output logic tx_cal_busy,
  output logic [4:0] bonding_master_index,
  output logic [1:0] tx_pll_input_count,
  output logic tx_pll_input_sel,
  output logic [1:0] rate_negotiation_unit_rate,
  output logic [13:0] lane_rate_mbps
);

  // ==========================================================
  // Helper functions
  function automatic logic [4:0] auto_master(input logic [2:0] code);
    case (code)
      W_X1: auto_master = MASTER_X1;
      W_X2: auto_master = MASTER_X2;
      W_X4: auto_master = MASTER_X4;
      W_X8: auto_master = MASTER_X8;
      W_X16: auto_master = MASTER_X16;
      default: auto_master = MASTER_X1;
    endcase
  endfunction : auto_master

  function automatic logic [13:0] rate_mbps(input logic [1:0] code);
    case (code)
      GEN2: rate_mbps = GEN2_MBPS;
      GEN3: rate_mbps = GEN3_MBPS;
      default: rate_mbps = GEN1_MBPS;
    endcase
  endfunction : rate_mbps

  // ==========================================================
  // Control register
  logic [2:0] width_q;
  logic manual_q;
  logic [4:0] manual_master_q;
  logic [1:0] rate_q;
  logic [2:0] first_slot_q;
  logic pll_sel_q;
  logic [31:0] rdata_q;

  // Decode of the register port
  logic wr_ctrl;
  logic [2:0] width_w;
  logic [1:0] rate_w;
  logic single_gen3;
  logic sel_allowed;
  assign wr_ctrl = wr && (addr == ADDR_CTRL);
  assign width_w = wdata[CTRL_WIDTH_LSB +: 3];
  assign rate_w = wdata[CTRL_RATE_LSB +: 2];
  assign single_gen3 = (width_q == W_X1) && (rate_q == GEN3);
  // The second PLL input exists only on a single-lane Gen3 channel
  assign sel_allowed = (width_w == W_X1) && (rate_w == GEN3);

  // Rate survives every reset hold so the rate negotiation unit state is
  // kept; only the block reset brings the link back to Gen1
  always_ff @(posedge clk) begin
    if (reset) begin
      width_q <= W_X1;
      manual_q <= 1'b0;
      manual_master_q <= MASTER_X1;
      rate_q <= GEN1; // R16
      first_slot_q <= 3'h0;
      pll_sel_q <= 1'b0; // R17
    end else if (wr_ctrl) begin
      width_q <= (width_w > W_X16) ? width_q : width_w;
      manual_q <= wdata[CTRL_MANUAL_BIT];
      manual_master_q <= wdata[CTRL_MASTER_LSB +: 5];
      rate_q <= (rate_w > GEN3) ? rate_q : rate_w;
      first_slot_q <= (wdata[CTRL_FIRST_LSB +: 3] < BANK_SLOTS) ?
                      wdata[CTRL_FIRST_LSB +: 3] : first_slot_q;
      pll_sel_q <= wdata[CTRL_PLLSEL_BIT] && sel_allowed; // R17
    end
  end

  // ==========================================================
  // Bonding master and bank placement
  logic [4:0] master_w;
  logic [5:0] phys_sum;
  logic [2:0] master_slot;
  logic placement_ok;
  assign master_w = manual_q ? manual_master_q : auto_master(width_q); // R14 R15
  // Lane 0 sits at first_slot_q; the master lands master_w slots above, wrapping at BANK_SLOTS
  assign phys_sum = 6'(first_slot_q) + 6'(master_w);
  assign master_slot = 3'(phys_sum % 6'(BANK_SLOTS));
  // A bonding master outside slot 1 or 4 cannot drive the bonding clocks
  assign placement_ok = (master_slot == MASTER_SLOT_A) ||
                        (master_slot == MASTER_SLOT_B); // R15
  assign bonding_master_index = master_w;

  // ==========================================================
  // Lane rate and PLL inputs
  assign rate_negotiation_unit_rate = rate_q; // R16
  assign lane_rate_mbps = rate_mbps(rate_q); // R16
  assign tx_pll_input_count = single_gen3 ? PLL_INPUTS_TWO : PLL_INPUTS_ONE; // R17
  assign tx_pll_input_sel = pll_sel_q && single_gen3; // R17

  // ==========================================================
  // Reset acknowledge trackers
  reset_ack_tracker #(
    .SETTLE(CGB_SETTLE_CYCLES)
  ) u_cgb_ack (
    .clk(clk),
    .reset(reset),
    .req(clock_gen_block_reset),
    .ack_q(clock_gen_block_reset_ack)
  );

  // The analog acknowledge reports the PMA state, not the hold request
  reset_ack_tracker #(
    .SETTLE(ANALOG_SETTLE_CYCLES)
  ) u_ana_ack (
    .clk(clk),
    .reset(reset),
    .req(tx_analog_hold), // R4 R6
    .ack_q(tx_analog_reset_ack)
  );

  reset_ack_tracker #(
    .SETTLE(PCS_SETTLE_CYCLES)
  ) u_pcs_ack (
    .clk(clk),
    .reset(reset),
    .req(tx_pcs_hold),
    .ack_q(tx_pcs_reset_ack)
  );

  // ==========================================================
  // Calibration after reset and PLL lock
  logic [11:0] cal_cnt_q;
  logic [11:0] lock_cnt_q;
  logic locked_q;
  logic cal_running;
  logic lock_settled;
  assign cal_running = (cal_cnt_q != PLL_CAL_CYCLES);
  assign lock_settled = (lock_cnt_q == LOCK_CYCLES);
  assign pll_cal_busy = cal_running;
  assign tx_cal_busy = (cal_cnt_q < TX_CAL_CYCLES);

  // Calibration runs once after reset; lock is lost while the clock
  // generation block is in reset and comes back after a settle time
  always_ff @(posedge clk) begin
    if (reset) begin
      cal_cnt_q <= 12'h000;
      lock_cnt_q <= 12'h000;
      locked_q <= 1'b0;
    end else begin
      if (cal_running) begin
        cal_cnt_q <= cal_cnt_q + 12'h001;
      end
      if (clock_gen_block_reset_ack || cal_running) begin
        lock_cnt_q <= 12'h000;
        locked_q <= 1'b0;
      end else if (!lock_settled) begin
        lock_cnt_q <= lock_cnt_q + 12'h001;
      end else begin
        locked_q <= 1'b1;
      end
    end
  end
  assign pll_locked = locked_q;

  // ==========================================================
  // Register read path
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] read_mux;
  assign ctrl_word = {17'h00000, pll_sel_q, first_slot_q, rate_q,
                      manual_master_q, manual_q, width_q};
  assign status_word = {14'h0000, tx_pll_input_count, 3'h0, master_w, 1'b0,
                        placement_ok, tx_cal_busy, pll_cal_busy, locked_q,
                        tx_pcs_reset_ack, tx_analog_reset_ack,
                        clock_gen_block_reset_ack};
  // Unmapped addresses read as zero
  assign read_mux = (addr == ADDR_CTRL) ? ctrl_word :
                    (addr == ADDR_STATUS) ? status_word :
                    (addr == ADDR_RATE) ? {18'h00000, lane_rate_mbps} :
                    32'h00000000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rd ? read_mux : 32'h00000000;
    end
  end
  assign rdata = rdata_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence ana_held_s;
    $rose(tx_analog_hold) && !tx_analog_reset_ack ##0 tx_analog_hold[*4];
  endsequence

  sequence ana_freed_s;
    $fell(tx_analog_hold) && tx_analog_reset_ack ##0 !tx_analog_hold[*4];
  endsequence

  a_analog_ack_rise: assert property (ana_held_s |=> tx_analog_reset_ack) // R4
    else $error("analog acknowledge did not rise after hold settled");

  a_analog_ack_fall: assert property (ana_freed_s |=> !tx_analog_reset_ack) // R6
    else $error("analog acknowledge did not fall after release settled");

  a_analog_ack_cause: assert property ($changed(tx_analog_reset_ack) |-> // R4 R6
      tx_analog_reset_ack == $past(tx_analog_hold))
    else $error("analog acknowledge moved against the hold");

  a_master_x16_x8: assert property (!manual_q && (width_q == W_X16 || // R14
      width_q == W_X8) |-> bonding_master_index == (width_q == W_X16 ?
      MASTER_X16 : MASTER_X8))
    else $error("wrong auto bonding master index");

  a_placement_slot: assert property (placement_ok |-> // R15
      (6'(first_slot_q) + 6'(bonding_master_index)) % 6'(BANK_SLOTS) == 6'(MASTER_SLOT_A)
      || (6'(first_slot_q) + 6'(bonding_master_index)) % 6'(BANK_SLOTS)
      == 6'(MASTER_SLOT_B))
    else $error("placement flag set on a wrong slot");

  a_powerup_rate: assert property ($fell(reset) |-> // R16
      lane_rate_mbps == GEN1_MBPS && !tx_pll_input_sel)
    else $error("link did not power up at Gen1 on input 0");

  a_pll_input_count: assert property ((tx_pll_input_count == PLL_INPUTS_TWO) == // R17
      (width_q == W_X1 && lane_rate_mbps == GEN3_MBPS)
      && (!tx_pll_input_sel || tx_pll_input_count == PLL_INPUTS_TWO))
    else $error("PLL input count or selection wrong");

  // Auto master for the narrow widths; a wrong index would bond the
  // lanes to a channel that cannot drive the bonding clocks
  a_master_x1: assert property (!manual_q && width_q == W_X1 |-> // R14
      bonding_master_index == MASTER_X1)
    else $error("wrong auto bonding master index for one lane");

  a_master_x2: assert property (!manual_q && width_q == W_X2 |-> // R14
      bonding_master_index == MASTER_X2)
    else $error("wrong auto bonding master index for two lanes");

  a_master_x4: assert property (!manual_q && width_q == W_X4 |-> // R14
      bonding_master_index == MASTER_X4)
    else $error("wrong auto bonding master index for four lanes");

  // An acknowledge edge needs the hold steady for the whole settle time,
  // so a short glitch on the hold never reaches the controller
  a_analog_rise_settle: assert property ($rose(tx_analog_reset_ack) |-> // R4
      $past(tx_analog_hold, 1) && $past(tx_analog_hold, 2) &&
      $past(tx_analog_hold, 3) && $past(tx_analog_hold, 4))
    else $error("analog acknowledge rose before the hold settled");

  a_analog_fall_settle: assert property ($fell(tx_analog_reset_ack) |-> // R6
      !$past(tx_analog_hold, 1) && !$past(tx_analog_hold, 2) &&
      !$past(tx_analog_hold, 3) && !$past(tx_analog_hold, 4))
    else $error("analog acknowledge fell before the release settled");

  // Only a register write may move the rate; reset holds must not
  a_rate_kept: assert property (!wr_ctrl |=> $stable(rate_q)) // R16
    else $error("link rate moved without a register write");

  // The select bit cannot stick once the channel leaves x1 Gen3
  a_pll_sel_input0: assert property (!single_gen3 |-> !tx_pll_input_sel) // R17
    else $error("PLL input 1 selected outside single-lane Gen3");

endmodule : pipe_tx_channel

// [shared/pipe_tx_pkg.sv]
package pipe_tx_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RATE = 8'h08;

  // ==========================================================
  // Control register fields
  localparam int CTRL_WIDTH_LSB = 0;   // Lane width code, 3 bits
  localparam int CTRL_MANUAL_BIT = 3;  // Manual bonding master select
  localparam int CTRL_MASTER_LSB = 4;  // Manual master index, 5 bits
  localparam int CTRL_RATE_LSB = 9;    // Link rate code, 2 bits
  localparam int CTRL_FIRST_LSB = 11;  // Physical bank slot of lane 0, 3 bits
  localparam int CTRL_PLLSEL_BIT = 14; // TX PLL clock input select

  // Status register fields
  localparam int ST_CGB_ACK_BIT = 0;
  localparam int ST_ANA_ACK_BIT = 1;
  localparam int ST_PCS_ACK_BIT = 2;
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_PLL_BUSY_BIT = 4;
  localparam int ST_TX_BUSY_BIT = 5;
  localparam int ST_PLACE_OK_BIT = 6;
  localparam int ST_MASTER_LSB = 8;    // 5 bits
  localparam int ST_INPUTS_LSB = 16;   // 2 bits

  // ==========================================================
  // Lane widths and link rates
  typedef enum logic [2:0] {W_X1, W_X2, W_X4, W_X8, W_X16} width_t;
  typedef enum logic [1:0] {GEN1, GEN2, GEN3} rate_t;

  localparam logic [13:0] GEN1_MBPS = 14'h09C4;  // 2.5 Gbps
  localparam logic [13:0] GEN2_MBPS = 14'h1388;  // 5 Gbps
  localparam logic [13:0] GEN3_MBPS = 14'h1F40;  // 8 Gbps

  localparam logic [4:0] MASTER_X1 = 5'h00;
  localparam logic [4:0] MASTER_X2 = 5'h01;
  localparam logic [4:0] MASTER_X4 = 5'h02;
  localparam logic [4:0] MASTER_X8 = 5'h04;
  localparam logic [4:0] MASTER_X16 = 5'h08;

  localparam logic [2:0] BANK_SLOTS = 3'h6;      // Channels per bank
  localparam logic [2:0] MASTER_SLOT_A = 3'h1;
  localparam logic [2:0] MASTER_SLOT_B = 3'h4;

  localparam logic [1:0] PLL_INPUTS_ONE = 2'h1;
  localparam logic [1:0] PLL_INPUTS_TWO = 2'h2;

  // ==========================================================
  // Settling and calibration times, in clock cycles
  localparam int CGB_SETTLE_CYCLES = 4;
  localparam int ANALOG_SETTLE_CYCLES = 4;
  localparam int PCS_SETTLE_CYCLES = 4;
  localparam logic [11:0] LOCK_CYCLES = 12'h020;
  localparam logic [11:0] PLL_CAL_CYCLES = 12'h040;
  localparam logic [11:0] TX_CAL_CYCLES = 12'h030;

endpackage : pipe_tx_pkg

// [verilog/reset_ack_tracker.sv]
`timescale 1ns/1ps
module reset_ack_tracker #(
  parameter int SETTLE = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic req,
  output logic ack_q
);

  // ==========================================================
  // Settling counter
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic mismatch;
  logic settled;

  // The block only reports a change once the request held steady long
  // enough; a glitch on the request restarts the count
  assign mismatch = (req != ack_q);
  assign settled = (cnt_q == 8'(SETTLE - 1));
  assign cnt_d = (mismatch && !settled) ? cnt_q + 8'h01 : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (mismatch && settled) begin
        ack_q <= req;
      end
    end
  end

endmodule : reset_ack_tracker

// [bench/tx_reset_ctrl_model.sv]
`timescale 1ns/1ps
module tx_reset_ctrl_model #(
  parameter int MIN_GAP = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic gen_ack,
  input wire logic ana_ack,
  input wire logic pcs_ack,
  input wire logic lock_raw,
  input wire logic pll_busy,
  input wire logic tx_busy,
  output logic gen_reset,
  output logic ana_hold,
  output logic pcs_hold,
  output logic busy
);
  // ==========================================================
  // Sequencer
  logic cal_busy;
  logic lock_seen;
  logic ana_hold_q;
  logic [2:0] step_q;
  int gap_q;
  // No dedicated PLL busy input, so both busy flags are merged
  assign cal_busy = pll_busy | tx_busy;
  assign lock_seen = lock_raw & ~gen_ack;
  assign ana_hold = gen_ack ? ana_hold_q : 1'b0;
  // One step per edge; PCS hold moves only inside a run, so rate state survives
  always @(posedge clk) begin
    if (reset) begin
      step_q <= 3'h0;
      gen_reset <= 1'b0;
      ana_hold_q <= 1'b0;
      pcs_hold <= 1'b0;
      busy <= 1'b0;
      gap_q <= 0;
    end else begin
      case (step_q)
        3'h0: if (start) begin
          gen_reset <= 1'b1;
          busy <= 1'b1;
          step_q <= 3'h1;
        end
        3'h1: if (gen_ack && !cal_busy) begin
          ana_hold_q <= 1'b1;
          pcs_hold <= 1'b1;
          step_q <= 3'h2;
        end
        3'h2: if (ana_ack && pcs_ack) begin
          ana_hold_q <= 1'b0;
          step_q <= 3'h3;
        end
        3'h3: if (!ana_ack) begin
          gen_reset <= 1'b0;
          step_q <= 3'h4;
        end
        3'h4: if (!gen_ack && lock_seen) begin
          gap_q <= 0;
          step_q <= 3'h5;
        end
        3'h5: if (gap_q == MIN_GAP) begin
          pcs_hold <= 1'b0;
          step_q <= 3'h6;
        end else begin
          gap_q <= gap_q + 1;
        end
        default: if (!pcs_ack) begin
          busy <= 1'b0;
          step_q <= 3'h0;
        end
      endcase
    end
  end
endmodule : tx_reset_ctrl_model

// [bench/pipe_tx_channel_bench.sv]
`timescale 1ns/1ps
module pipe_tx_channel_bench;
  import pipe_tx_pkg::*;
  // ==========================================================
  // Signals
  localparam logic [4:0] MST [5] = '{MASTER_X1, MASTER_X2, MASTER_X4, MASTER_X8, MASTER_X16};
  localparam logic [13:0] MBPS [3] = '{GEN1_MBPS, GEN2_MBPS, GEN3_MBPS};
  logic clk = 1'b0;
  logic reset, wr, rd, start, gen_rst, ana_hold, pcs_hold, ctl_busy;
  logic hold_d = 1'b0;
  logic ack_d = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic gen_ack, ana_ack, pcs_ack, locked, pll_busy, tx_busy, pll_sel;
  logic [4:0] master;
  logic [1:0] n_inputs, rate_code;
  logic [13:0] mbps;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_hold = 0;
  // Half period of 2.5 ns gives 200 MHz
  always #2.5 clk = ~clk;
  pipe_tx_channel dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .clock_gen_block_reset(gen_rst), .tx_analog_hold(ana_hold),
    .tx_pcs_hold(pcs_hold), .clock_gen_block_reset_ack(gen_ack),
    .tx_analog_reset_ack(ana_ack), .tx_pcs_reset_ack(pcs_ack), .pll_locked(locked),
    .pll_cal_busy(pll_busy), .tx_cal_busy(tx_busy), .bonding_master_index(master),
    .tx_pll_input_count(n_inputs), .tx_pll_input_sel(pll_sel),
    .rate_negotiation_unit_rate(rate_code), .lane_rate_mbps(mbps));
  tx_reset_ctrl_model #(.MIN_GAP(8)) ctl (.clk(clk), .reset(reset), .start(start),
    .gen_ack(gen_ack), .ana_ack(ana_ack), .pcs_ack(pcs_ack), .lock_raw(locked),
    .pll_busy(pll_busy), .tx_busy(tx_busy), .gen_reset(gen_rst), .ana_hold(ana_hold),
    .pcs_hold(pcs_hold), .busy(ctl_busy));
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Edge before each strobe keeps one assignment per signal per time step
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : rd_reg
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // Monitor: analog acknowledge follows the hold after the settle time
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hold_d <= ana_hold;
    ack_d <= ana_ack;
    if (!reset && ana_hold !== hold_d) begin
      t_hold <= cyc;
    end
    if (!reset && ana_ack !== ack_d) begin
      check({31'h0, (cyc - t_hold) == ANALOG_SETTLE_CYCLES}, 32'h1);
    end
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    start = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd_reg(ADDR_STATUS, d);
    check(d, 32'h0001_0030);
    rd_reg(ADDR_RATE, d);
    check(d, {18'h0, GEN1_MBPS});
    for (int i = 0; i < 5; i++) begin
      wr_reg(ADDR_CTRL, 32'(i));
      settle();
      check({27'h0, master}, {27'h0, MST[i]});
    end
    // Width code 5 is refused, so the x16 master must stay
    wr_reg(ADDR_CTRL, 32'h0000_0005);
    settle();
    check({27'h0, master}, {27'h0, MASTER_X16});
    for (int r = 0; r < 3; r++) begin
      wr_reg(ADDR_CTRL, 32'(r) << 9);
      settle();
      check({16'h0, rate_code, mbps}, {16'h0, 2'(r), MBPS[r]});
    end
    wr_reg(ADDR_CTRL, 32'h0000_0600);
    settle();
    check({18'h0, mbps}, {18'h0, GEN3_MBPS});
    wr_reg(ADDR_CTRL, 32'h0000_4400);
    settle();
    check({29'h0, n_inputs, pll_sel}, {29'h0, PLL_INPUTS_TWO, 1'b1});
    wr_reg(ADDR_CTRL, 32'h0000_0400);
    settle();
    check({29'h0, n_inputs, pll_sel}, {29'h0, PLL_INPUTS_TWO, 1'b0});
    wr_reg(ADDR_CTRL, 32'h0000_4402);
    settle();
    check({30'h0, n_inputs}, {30'h0, PLL_INPUTS_ONE});
    // Lane 0 in slot 2 puts the x4 master in slot 4; slot 0 puts it in slot 2
    wr_reg(ADDR_CTRL, 32'h0000_1402);
    rd_reg(ADDR_STATUS, d);
    check({31'h0, d[ST_PLACE_OK_BIT]}, 32'h1);
    wr_reg(ADDR_CTRL, 32'h0000_0402);
    rd_reg(ADDR_STATUS, d);
    check({31'h0, d[ST_PLACE_OK_BIT]}, 32'h0);
    wr_reg(ADDR_CTRL, 32'h0000_0C3A);
    rd_reg(ADDR_STATUS, d);
    check({26'h0, d[12:8], d[6]}, {26'h0, 5'h03, 1'b1});
    // Two full reset runs back to back at Gen3
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (2) @(posedge clk);
      for (int n = 0; n < 1000 && ctl_busy === 1'b1; n++) @(posedge clk);
      check({31'h0, ctl_busy}, 32'h0);
      check({28'h0, pcs_ack, ana_ack, gen_ack, locked}, 32'h1);
      check({30'h0, rate_code}, {30'h0, GEN3});
    end
    // A block reset after the runs returns the link to Gen1 on PLL input 0
    wr_reg(ADDR_CTRL, 32'h0000_4400);
    @(posedge clk);
    check({31'h0, pll_sel}, 32'h1);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    settle();
    check({13'h0, rate_code, pll_sel, n_inputs, mbps},
          {13'h0, GEN1, 1'b0, PLL_INPUTS_ONE, GEN1_MBPS});
    summarize();
  end
endmodule : pipe_tx_channel_bench
